// *** cpm_pkg.sv ***
/*
 * Constants and carrier types for the codec power, path and mode register bank.
 * Assumes an 8-bit register space with 5-bit addresses driven by the serial control port.
 */
package cpm_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int RAMP_W = 11;

    // Register offsets
    localparam logic [4:0] ADDR_POWER_ONE = 5'h00;
    localparam logic [4:0] ADDR_POWER_TWO = 5'h01;
    localparam logic [4:0] ADDR_SELECT_ONE = 5'h02;
    localparam logic [4:0] ADDR_SELECT_TWO = 5'h03;
    localparam logic [4:0] ADDR_MODE_ONE = 5'h04;
    localparam logic [4:0] ADDR_MODE_TWO = 5'h05;
    localparam logic [4:0] ADDR_DAC_CTRL = 5'h06;
    localparam logic [4:0] ADDR_LEFT_ATT = 5'h0c;
    localparam logic [4:0] ADDR_RIGHT_ATT = 5'h0d;
    localparam logic [4:0] ADDR_POWER_THREE = 5'h10;

    // Reset values
    localparam logic [7:0] RST_POWER_ONE = 8'h00;
    localparam logic [7:0] RST_POWER_TWO = 8'h80;
    localparam logic [7:0] RST_SELECT_ONE = 8'h00;
    localparam logic [7:0] RST_SELECT_TWO = 8'h03;
    localparam logic [7:0] RST_MODE_ONE = 8'h02;
    localparam logic [7:0] RST_MODE_TWO = 8'h00;
    localparam logic [7:0] RST_DAC_CTRL = 8'h11;
    localparam logic [7:0] RST_ATT = 8'h00;
    localparam logic [7:0] RST_POWER_THREE = 8'h00;

    // Writable bit masks; cleared bits are read-only zero
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_SELECT_TWO = 8'hdf;
    localparam logic [7:0] MASK_MODE_TWO = 8'he7;
    localparam logic [7:0] MASK_POWER_THREE = 8'h1f;

    // First power register bits
    localparam int P1_COMMON_VOLTAGE = 7;
    localparam int P1_STEREO_BEEP = 6;
    localparam int P1_MONO_BEEP = 5;
    localparam int P1_LINE_OUT = 4;
    localparam int P1_MONO_OUT = 3;
    localparam int P1_LEFT_GAIN = 2;
    localparam int P1_LEFT_MIC = 1;
    localparam int P1_LEFT_ADC = 0;
    // Second power register bits
    localparam int P2_CLOCK_PULLDOWN = 7;
    localparam int P2_CRYSTAL = 6;
    localparam int P2_PLL = 5;
    localparam int P2_SPEAKER_GAIN = 4;
    localparam int P2_SPEAKER = 3;
    localparam int P2_LEFT_HP_COMMON = 2;
    localparam int P2_RIGHT_HP_COMMON = 1;
    localparam int P2_DAC = 0;
    // Third power register bits
    localparam int P3_RIGHT_GAIN = 2;
    localparam int P3_RIGHT_MIC = 1;
    localparam int P3_RIGHT_ADC = 0;
    // First signal select bits
    localparam int S1_MONO_GAIN = 7;
    localparam int S1_MONO_SAVE = 6;
    localparam int S1_DAC_MONO = 5;
    localparam int S1_MIC_MONO = 4;
    localparam int S1_SBEEP_SPK = 3;
    localparam int S1_MBEEP_SPK = 2;
    localparam int S1_LEVEL_SPK = 1;
    localparam int S1_SECOND_MONO_OUTPUT_ENABLE_EN = 0;
    // Second signal select bits
    localparam int S2_DAC_STEREO = 7;
    localparam int S2_LINE_SAVE = 6;
    localparam int S2_MIC_STEREO = 4;
    localparam int S2_SBEEP_HP = 3;
    localparam int S2_MBEEP_HP = 2;
    localparam int S2_LEFT_HP_OFF = 1;
    localparam int S2_RIGHT_HP_OFF = 0;
    // Mode fields
    localparam int M1_PLL_SEL_LSB = 6;
    localparam int M1_CLK_RATIO_LSB = 4;
    localparam int M1_MCLK_OUT = 3;
    localparam int M1_BCLK_RATIO = 2;
    localparam int M1_FORMAT_LSB = 0;
    localparam int M2_RATE_LSB = 5;
    localparam int M2_HP_MONO = 2;
    localparam int M2_LOOPBACK = 1;
    localparam int M2_SPK_SAVE = 0;
    // DAC control fields
    localparam int D_MUTE_TIME_LSB = 6;
    localparam int D_SOFT_MUTE = 5;
    localparam int D_ATT_LINK = 4;
    localparam int D_BOOST_LSB = 2;
    localparam int D_DEEMPH_LSB = 0;

    // Soft mute ramp length in samples, indexed by the time code
    localparam logic [10:0] MUTE_RAMP_LEN [4] = '{11'h400, 11'h200, 11'h100, 11'h080};

    typedef enum logic [1:0] {
        SECOND_MONO_OUTPUT_ENABLE_HIZ = 2'b00,
        SECOND_MONO_OUTPUT_ENABLE_COMMON_VOLTAGE = 2'b01,
        SECOND_MONO_OUTPUT_ENABLE_MIX = 2'b10
    } cpm_second_mono_output_enable_t;

    typedef struct packed {
        logic common_voltage;
        logic stereo_beep;
        logic mono_beep;
        logic line_out;
        logic mono_out;
        logic left_mic;
        logic left_input_gain;
        logic left_adc;
        logic right_mic;
        logic right_input_gain;
        logic right_adc;
        logic dac;
        logic speaker;
        logic left_hp_common;
        logic right_hp_common;
        logic pll;
        logic crystal_osc;
        logic clock_input_pulldown;
        logic speaker_high_power;
        logic input_gain_stage_gain_reset;
    } cpm_power_t;

    typedef struct packed {
        logic stereo_beep_to_headphone;
        logic mono_beep_to_headphone;
        logic stereo_beep_to_speaker;
        logic mono_beep_to_speaker;
        logic level_control_to_speaker;
        logic mic_to_mono_line;
        logic dac_to_mono_line;
        logic mono_line_active;
        logic mono_line_gain_low;
        logic mic_to_stereo_outputs;
        logic dac_to_stereo_outputs;
        logic line_output_active;
        logic left_headphone_on;
        logic right_headphone_on;
        logic headphone_mono;
        logic speaker_normal;
        cpm_second_mono_output_enable_t second_mono_output_enable_mode;
    } cpm_route_t;

    typedef struct packed {
        logic [1:0] audio_format;
        logic bit_clock_32fs;
        logic master_clock_out_en;
        logic [1:0] output_clock_ratio;
        logic [1:0] pll_input_select;
        logic [2:0] sample_rate_mode;
        logic loopback;
    } cpm_mode_t;

    typedef struct packed {
        logic [1:0] deemphasis;
        logic [1:0] bass_boost;
        logic soft_mute;
        logic [10:0] mute_ramp_len;
        logic [7:0] left_att;
        logic [7:0] right_att;
    } cpm_dac_t;

endpackage : cpm_pkg

// *** cpm_sync.sv ***
/*
 * Two-flop synchroniser for asynchronous level inputs, one chain per bit.
 * Assumes the inputs are slow levels; only the second flop is read outside.
 */
`timescale 1ns/1ps
module cpm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [WIDTH-1:0] D,
    output logic [WIDTH-1:0] Q
);

    logic [WIDTH-1:0] meta_q;

    // One two-flop chain per input bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge CLK)
            begin
                if (!RSTN)
                begin
                    meta_q[i] <= 1'b0;
                    Q[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= D[i];
                    Q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule : cpm_sync

// *** cpm_regs.sv ***
/*
 * Power, signal path and mode control register bank of the stereo codec.
 * Assumes the serial control port decodes frames into write and read strobes
 * with a register address, all on CLK; audio words arrive on CLK as well.
 */
// Functional notes
// - Stereo beep power bit low never cuts beep routes; only route bits do.
// - Each power bit gates its own block; power-down pin low turns everything off.
// - All power bits zero except pull-down: everything off, registers kept.
// - Input gain reset while both mic and both input gain power bits are zero.
// - Second mono output: common voltage at zero, half mix at one, high-Z unpowered.
// - Level control, mono beep and stereo beep mix into speaker when set.
// - Mono line carries left input gain or DAC per its route bits.
// - Mono line power save parks pins; gain bit picks +6dB or -17dB.
// - Headphone off bits default one; beep route bits mix into headphone.
// - DAC and mic routes feed stereo outputs; line select needs line power.
// - Format defaults to 10; bit clock ratio 64/32fs only in master mode.
// - Clock output off, ratio 256fs, PLL input 12.288MHz after reset.
// - Speaker save bit acts only with speaker power; speaker off after power-down.
// - Loopback routes ADC words to DAC and ignores serial playback data.
// - Headphone mono drives half mix to both headphone channels.
// - Sample rate mode resets to 000 for 44.1kHz.
// - De-emphasis resets to 01 (off); bass boost resets to 00 (off).
// - Attenuator link: left field drives both channels; right register unchanged.
// - Soft mute acts digitally, independent of attenuation.
// - Clock input pull-down defaults one; PLL bit zero selects external clock.
// - Power-down pin low returns every register to default.
// - Soft mute time codes give 1024, 512, 256, 128 sample ramps.
`timescale 1ns/1ps
module cpm_regs (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic POWER_DOWN_PIN_N,
    input wire logic MASTER_MODE_PIN,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic RD_VALID,
    input wire logic [15:0] ADC_WORD,
    input wire logic [15:0] SERIAL_WORD,
    output logic [15:0] DAC_WORD,
    output cpm_pkg::cpm_power_t POWER,
    output cpm_pkg::cpm_route_t ROUTE,
    output cpm_pkg::cpm_mode_t MODE,
    output cpm_pkg::cpm_dac_t DAC
);

    logic [1:0] pin_s;
    logic pdn_s;
    logic master_s;
    logic clr;
    logic [7:0] pm1_q, pm2_q, pm3_q, sel1_q, sel2_q, mode1_q, mode2_q, dacc_q, attl_q, attr_q;
    logic [7:0] rdata_d;
    logic all_off;
    logic on;

    // Pins cross into CLK through two flops
    cpm_sync #(.WIDTH(2)) cpm_sync_inst (
        .CLK(CLK),
        .RSTN(RSTN),
        .D({POWER_DOWN_PIN_N, MASTER_MODE_PIN}),
        .Q(pin_s)
    );
    assign pdn_s = pin_s[1];
    assign master_s = pin_s[0];
    assign clr = !RSTN || !pdn_s;

    // Register writes; reserved bits masked off on the way in
    always_ff @(posedge CLK)
    begin
        if (clr)
        begin
            pm1_q <= cpm_pkg::RST_POWER_ONE;
            pm2_q <= cpm_pkg::RST_POWER_TWO;
            pm3_q <= cpm_pkg::RST_POWER_THREE;
            sel1_q <= cpm_pkg::RST_SELECT_ONE;
            sel2_q <= cpm_pkg::RST_SELECT_TWO;
            mode1_q <= cpm_pkg::RST_MODE_ONE;
            mode2_q <= cpm_pkg::RST_MODE_TWO;
            dacc_q <= cpm_pkg::RST_DAC_CTRL;
            attl_q <= cpm_pkg::RST_ATT;
            attr_q <= cpm_pkg::RST_ATT;
        end
        else if (WR_STB)
        begin
            case (ADDR)
                cpm_pkg::ADDR_POWER_ONE: pm1_q <= WDATA;
                cpm_pkg::ADDR_POWER_TWO: pm2_q <= WDATA;
                cpm_pkg::ADDR_POWER_THREE: pm3_q <= WDATA & cpm_pkg::MASK_POWER_THREE;
                cpm_pkg::ADDR_SELECT_ONE: sel1_q <= WDATA;
                cpm_pkg::ADDR_SELECT_TWO: sel2_q <= WDATA & cpm_pkg::MASK_SELECT_TWO;
                cpm_pkg::ADDR_MODE_ONE: mode1_q <= WDATA;
                cpm_pkg::ADDR_MODE_TWO: mode2_q <= WDATA & cpm_pkg::MASK_MODE_TWO;
                cpm_pkg::ADDR_DAC_CTRL: dacc_q <= WDATA;
                cpm_pkg::ADDR_LEFT_ATT: attl_q <= WDATA;
                cpm_pkg::ADDR_RIGHT_ATT: attr_q <= WDATA;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (ADDR)
            cpm_pkg::ADDR_POWER_ONE: rdata_d = pm1_q;
            cpm_pkg::ADDR_POWER_TWO: rdata_d = pm2_q;
            cpm_pkg::ADDR_POWER_THREE: rdata_d = pm3_q;
            cpm_pkg::ADDR_SELECT_ONE: rdata_d = sel1_q;
            cpm_pkg::ADDR_SELECT_TWO: rdata_d = sel2_q;
            cpm_pkg::ADDR_MODE_ONE: rdata_d = mode1_q;
            cpm_pkg::ADDR_MODE_TWO: rdata_d = mode2_q;
            cpm_pkg::ADDR_DAC_CTRL: rdata_d = dacc_q;
            cpm_pkg::ADDR_LEFT_ATT: rdata_d = attl_q;
            cpm_pkg::ADDR_RIGHT_ATT: rdata_d = attr_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data captured one cycle after the strobe
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            RDATA <= 8'h00;
            RD_VALID <= 1'b0;
        end
        else
        begin
            RD_VALID <= RD_STB;
            if (RD_STB)
            begin
                RDATA <= rdata_d;
            end
        end
    end

    // Global power gate: pin low or every power bit but the pull-down clear
    assign all_off = (pm1_q == 8'h00) && (pm3_q == 8'h00)
        && (pm2_q[cpm_pkg::P2_CLOCK_PULLDOWN-1:0] == 7'h00);
    assign on = pdn_s && !all_off;

    // Block power enables, each bit gating its own block; mic bits also power their input gain stage
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            POWER <= '0;
            POWER.clock_input_pulldown <= 1'b1;
            POWER.input_gain_stage_gain_reset <= 1'b1;
        end
        else
        begin
            POWER.common_voltage <= on && pm1_q[cpm_pkg::P1_COMMON_VOLTAGE];
            POWER.stereo_beep <= on && pm1_q[cpm_pkg::P1_STEREO_BEEP];
            POWER.mono_beep <= on && pm1_q[cpm_pkg::P1_MONO_BEEP];
            POWER.line_out <= on && pm1_q[cpm_pkg::P1_LINE_OUT];
            POWER.mono_out <= on && pm1_q[cpm_pkg::P1_MONO_OUT];
            POWER.left_mic <= on && pm1_q[cpm_pkg::P1_LEFT_MIC];
            POWER.left_input_gain <= on
                && (pm1_q[cpm_pkg::P1_LEFT_MIC] || pm1_q[cpm_pkg::P1_LEFT_GAIN]);
            POWER.left_adc <= on && pm1_q[cpm_pkg::P1_LEFT_ADC];
            POWER.right_mic <= on && pm3_q[cpm_pkg::P3_RIGHT_MIC];
            POWER.right_input_gain <= on
                && (pm3_q[cpm_pkg::P3_RIGHT_MIC] || pm3_q[cpm_pkg::P3_RIGHT_GAIN]);
            POWER.right_adc <= on && pm3_q[cpm_pkg::P3_RIGHT_ADC];
            POWER.dac <= on && pm2_q[cpm_pkg::P2_DAC];
            POWER.speaker <= on && pm2_q[cpm_pkg::P2_SPEAKER];
            POWER.left_hp_common <= on && pm2_q[cpm_pkg::P2_LEFT_HP_COMMON];
            POWER.right_hp_common <= on && pm2_q[cpm_pkg::P2_RIGHT_HP_COMMON];
            POWER.pll <= on && pm2_q[cpm_pkg::P2_PLL];
            POWER.crystal_osc <= on && pm2_q[cpm_pkg::P2_CRYSTAL];
            POWER.clock_input_pulldown <= pm2_q[cpm_pkg::P2_CLOCK_PULLDOWN];
            POWER.speaker_high_power <= pm2_q[cpm_pkg::P2_SPEAKER_GAIN];
            POWER.input_gain_stage_gain_reset <= !(pm1_q[cpm_pkg::P1_LEFT_MIC] || pm1_q[cpm_pkg::P1_LEFT_GAIN]
                || pm3_q[cpm_pkg::P3_RIGHT_MIC] || pm3_q[cpm_pkg::P3_RIGHT_GAIN]);
        end
    end

    // Analog routing selects; beep routes ignore the beep power bits
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ROUTE <= '0;
            ROUTE.second_mono_output_enable_mode <= cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ;
        end
        else
        begin
            ROUTE.stereo_beep_to_headphone <= sel2_q[cpm_pkg::S2_SBEEP_HP];
            ROUTE.mono_beep_to_headphone <= sel2_q[cpm_pkg::S2_MBEEP_HP];
            ROUTE.stereo_beep_to_speaker <= sel1_q[cpm_pkg::S1_SBEEP_SPK];
            ROUTE.mono_beep_to_speaker <= sel1_q[cpm_pkg::S1_MBEEP_SPK];
            ROUTE.level_control_to_speaker <= sel1_q[cpm_pkg::S1_LEVEL_SPK];
            ROUTE.mic_to_mono_line <= sel1_q[cpm_pkg::S1_MIC_MONO];
            ROUTE.dac_to_mono_line <= sel1_q[cpm_pkg::S1_DAC_MONO];
            ROUTE.mono_line_active <= sel1_q[cpm_pkg::S1_MONO_SAVE];
            ROUTE.mono_line_gain_low <= sel1_q[cpm_pkg::S1_MONO_GAIN];
            ROUTE.mic_to_stereo_outputs <= sel2_q[cpm_pkg::S2_MIC_STEREO];
            ROUTE.dac_to_stereo_outputs <= sel2_q[cpm_pkg::S2_DAC_STEREO];
            ROUTE.line_output_active <= on && pm1_q[cpm_pkg::P1_LINE_OUT]
                && sel2_q[cpm_pkg::S2_LINE_SAVE];
            ROUTE.left_headphone_on <= !sel2_q[cpm_pkg::S2_LEFT_HP_OFF];
            ROUTE.right_headphone_on <= !sel2_q[cpm_pkg::S2_RIGHT_HP_OFF];
            ROUTE.headphone_mono <= mode2_q[cpm_pkg::M2_HP_MONO];
            ROUTE.speaker_normal <= on && pm2_q[cpm_pkg::P2_SPEAKER]
                && mode2_q[cpm_pkg::M2_SPK_SAVE];
            if (!(on && pm2_q[cpm_pkg::P2_SPEAKER]))
                ROUTE.second_mono_output_enable_mode <= cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ;
            else if (sel1_q[cpm_pkg::S1_SECOND_MONO_OUTPUT_ENABLE_EN])
                ROUTE.second_mono_output_enable_mode <= cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_MIX;
            else
                ROUTE.second_mono_output_enable_mode <= cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_COMMON_VOLTAGE;
        end
    end

    // Clocking and serial format modes
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            MODE <= '0;
            MODE.audio_format <= cpm_pkg::RST_MODE_ONE[cpm_pkg::M1_FORMAT_LSB +: 2];
        end
        else
        begin
            MODE.audio_format <= mode1_q[cpm_pkg::M1_FORMAT_LSB +: 2];
            MODE.bit_clock_32fs <= master_s && mode1_q[cpm_pkg::M1_BCLK_RATIO];
            MODE.master_clock_out_en <= mode1_q[cpm_pkg::M1_MCLK_OUT];
            MODE.output_clock_ratio <= mode1_q[cpm_pkg::M1_CLK_RATIO_LSB +: 2];
            MODE.pll_input_select <= mode1_q[cpm_pkg::M1_PLL_SEL_LSB +: 2];
            MODE.sample_rate_mode <= mode2_q[cpm_pkg::M2_RATE_LSB +: 3];
            MODE.loopback <= mode2_q[cpm_pkg::M2_LOOPBACK];
        end
    end

    // DAC controls and effective attenuation
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            DAC <= '0;
            DAC.deemphasis <= cpm_pkg::RST_DAC_CTRL[cpm_pkg::D_DEEMPH_LSB +: 2];
            DAC.mute_ramp_len <= cpm_pkg::MUTE_RAMP_LEN[0];
        end
        else
        begin
            DAC.deemphasis <= dacc_q[cpm_pkg::D_DEEMPH_LSB +: 2];
            DAC.bass_boost <= dacc_q[cpm_pkg::D_BOOST_LSB +: 2];
            DAC.soft_mute <= dacc_q[cpm_pkg::D_SOFT_MUTE];
            DAC.mute_ramp_len <= cpm_pkg::MUTE_RAMP_LEN[
                dacc_q[cpm_pkg::D_MUTE_TIME_LSB +: 2]];
            DAC.left_att <= attl_q;
            DAC.right_att <= dacc_q[cpm_pkg::D_ATT_LINK] ? attl_q : attr_q;
        end
    end

    // DAC input word: loopback replaces serial playback data
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            DAC_WORD <= 16'h0000;
        else
            DAC_WORD <= mode2_q[cpm_pkg::M2_LOOPBACK] ? ADC_WORD : SERIAL_WORD;
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    AST_PIN_OFF: assert property (!pdn_s |=> !POWER.speaker && !POWER.dac
        && !POWER.common_voltage && !POWER.left_adc)
        else $error("Block powered while power-down pin low");
    AST_ALL_ZERO: assert property (pdn_s && all_off && !WR_STB
        |=> $stable(pm2_q) && $stable(dacc_q))
        else $error("Registers changed while all blocks off");
    AST_ALL_ZERO_OFF: assert property (all_off |=> !POWER.common_voltage && !POWER.pll)
        else $error("Block powered with all power bits clear");
    AST_BEEP_ROUTE: assert property (##1 ROUTE.stereo_beep_to_speaker
        == $past(sel1_q[cpm_pkg::S1_SBEEP_SPK]))
        else $error("Stereo beep speaker route wrong");
    AST_GAIN_RESET: assert property ($past(pm1_q[cpm_pkg::P1_LEFT_MIC])
        |-> !POWER.input_gain_stage_gain_reset)
        else $error("Gain reset with left mic powered");
    AST_SECOND_MONO_OUTPUT_ENABLE_HIZ: assert property (!pm2_q[cpm_pkg::P2_SPEAKER]
        |=> ROUTE.second_mono_output_enable_mode == cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ)
        else $error("Second mono output driven without speaker power");
    AST_LOOPBACK: assert property (mode2_q[cpm_pkg::M2_LOOPBACK]
        |=> DAC_WORD == $past(ADC_WORD))
        else $error("Loopback word not taken from converter");
    AST_RAMP: assert property (dacc_q[cpm_pkg::D_MUTE_TIME_LSB +: 2] == 2'b11
        |=> DAC.mute_ramp_len == cpm_pkg::MUTE_RAMP_LEN[3])
        else $error("Soft mute ramp length wrong");
    AST_LINK: assert property (WR_STB && ADDR == cpm_pkg::ADDR_LEFT_ATT && pdn_s
        && dacc_q[cpm_pkg::D_ATT_LINK] |=> $stable(attr_q) ##1 DAC.right_att == DAC.left_att)
        else $error("Linked attenuation wrong");
    AST_RSVD: assert property (RD_STB && ADDR == cpm_pkg::ADDR_MODE_TWO
        |=> (RDATA & ~cpm_pkg::MASK_MODE_TWO) == 8'h00)
        else $error("Reserved bits read nonzero");
    AST_DEFAULTS: assert property (!pdn_s |=> dacc_q == cpm_pkg::RST_DAC_CTRL
        && pm2_q == cpm_pkg::RST_POWER_TWO && sel2_q == cpm_pkg::RST_SELECT_TWO)
        else $error("Registers not at defaults after power-down");
    AST_SPK_SAVE: assert property (!pm2_q[cpm_pkg::P2_SPEAKER] |=> !ROUTE.speaker_normal)
        else $error("Speaker normal without speaker power");

    COV_LOOP: cover property (mode2_q[cpm_pkg::M2_LOOPBACK] ##1 RD_VALID);
    COV_LINK: cover property (WR_STB && ADDR == cpm_pkg::ADDR_LEFT_ATT
        && dacc_q[cpm_pkg::D_ATT_LINK]);
    COV_MIX: cover property (ROUTE.second_mono_output_enable_mode == cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_MIX);
    COV_ALL_OFF: cover property (pdn_s && all_off ##1 !all_off);

endmodule : cpm_regs

// *** cpm_host.sv ***
/*
 * Host model on the register port: single-byte writes and reads.
 * Assumes strobes are sampled on the rising CLK edge, read data one cycle later.
 */
`timescale 1ns/1ps
module cpm_host (
    input wire logic CLK,
    output logic WR_STB,
    output logic RD_STB,
    output logic [4:0] ADDR,
    output logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic RD_VALID
);
    // Bus idle at time zero
    initial
    begin
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        ADDR = 5'h00;
        WDATA = 8'h00;
    end

    // One write; address and data are scrambled once the strobe drops
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR_STB <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR_STB <= 1'b0;
        ADDR <= ~a;
        WDATA <= ~d;
    endtask : wr

    // One read; data taken at the edge where the valid pulse stands
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        @(posedge CLK);
        RD_STB <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD_STB <= 1'b0;
        ADDR <= ~a;
        @(posedge CLK);
        v = RD_VALID;
        d = RDATA;
    endtask : rd
endmodule : cpm_host

// *** test_cpm_regs.sv ***
/*
 * Self-checking bench for the codec control register bank.
 * Assumes the host model drives the register port; audio words come from here.
 */
`timescale 1ns/1ps
module test_cpm_regs;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pin_n = 1'b1;
    logic master = 1'b0;
    logic wr_stb, rd_stb, rd_valid, v;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [15:0] adc_word = 16'h1234;
    logic [15:0] ser_word = 16'habcd;
    logic [15:0] dac_word;
    cpm_pkg::cpm_power_t pw;
    cpm_pkg::cpm_route_t rt;
    cpm_pkg::cpm_mode_t md;
    cpm_pkg::cpm_dac_t dc;
    int error_cnt = 0;
    int compares = 0;

    // Clock runs without pause
    always #2.5 clk = ~clk;

    cpm_regs cpm_regs_inst (.CLK(clk), .RSTN(rstn), .POWER_DOWN_PIN_N(pin_n),
        .MASTER_MODE_PIN(master), .WR_STB(wr_stb), .RD_STB(rd_stb), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid), .ADC_WORD(adc_word),
        .SERIAL_WORD(ser_word), .DAC_WORD(dac_word), .POWER(pw), .ROUTE(rt),
        .MODE(md), .DAC(dc));
    cpm_host cpm_host_inst (.CLK(clk), .WR_STB(wr_stb), .RD_STB(rd_stb), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid));

    // Compare and report
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask : chk

    task automatic rchk(logic [4:0] a, logic [7:0] e);
        cpm_host_inst.rd(a, d, v);
        chk("rdata", d, e);
        chk("rd_valid", v, 1'b1);
    endtask : rchk

    // Write, then let the outputs follow
    task automatic wrs(logic [4:0] a, logic [7:0] x);
        cpm_host_inst.wr(a, x);
        repeat (2) @(posedge clk);
        #1;
    endtask : wrs

    task automatic t_defaults;
        logic [7:0] e [6] = '{8'h80, 8'h00, 8'h03, 8'h02, 8'h00, 8'h11};
        cpm_pkg::cpm_power_t ep = '{clock_input_pulldown: 1'b1, input_gain_stage_gain_reset: 1'b1,
            default: 1'b0};
        cpm_pkg::cpm_route_t er = '{second_mono_output_enable_mode: cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ, default: 1'b0};
        cpm_pkg::cpm_mode_t em = '{audio_format: 2'b10, default: '0};
        cpm_pkg::cpm_dac_t ed = '{deemphasis: 2'b01, mute_ramp_len: 11'h400, default: '0};
        for (int i = 0; i < 6; i++)
            rchk(5'(i + 1), e[i]);
        chk("pulldown", pw.clock_input_pulldown, 1'b1);
        chk("format", md.audio_format, 2'b10);
        chk("deemph", dc.deemphasis, 2'b01);
        chk("power_dflt", pw, ep);
        chk("route_dflt", rt, er);
        chk("mode_dflt", md, em);
        chk("dac_dflt", dc, ed);
    endtask : t_defaults

    task automatic t_power;
        cpm_pkg::cpm_power_t ep = '{common_voltage: 1'b1, left_mic: 1'b1, left_input_gain: 1'b1,
            speaker: 1'b1, clock_input_pulldown: 1'b1, default: 1'b0};
        cpm_pkg::cpm_route_t er = '{mono_line_gain_low: 1'b1, mono_line_active: 1'b1,
            dac_to_mono_line: 1'b1, mic_to_mono_line: 1'b1, stereo_beep_to_speaker: 1'b1,
            speaker_normal: 1'b1, second_mono_output_enable_mode: cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_MIX, default: 1'b0};
        wrs(5'h01, 8'h88);
        wrs(5'h00, 8'h82);
        chk("mic_gain", pw.left_input_gain, 1'b1);
        chk("gain_rst", pw.input_gain_stage_gain_reset, 1'b0);
        chk("power_on", pw, ep);
        wrs(5'h02, 8'h08);
        chk("beep_spk", rt.stereo_beep_to_speaker, 1'b1);
        chk("second_mono_output_enable", rt.second_mono_output_enable_mode, cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_COMMON_VOLTAGE);
        wrs(5'h02, 8'h09);
        wrs(5'h05, 8'h01);
        chk("second_mono_output_enable", rt.second_mono_output_enable_mode, cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_MIX);
        chk("spk_norm", rt.speaker_normal, 1'b1);
        wrs(5'h02, 8'hf9);
        chk("route_mono", rt, er);
        @(posedge clk) pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk("vcm_off", pw.common_voltage, 1'b0);
        @(posedge clk) pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(5'h01, 8'h80);
        rchk(5'h02, 8'h00);
        chk("second_mono_output_enable", rt.second_mono_output_enable_mode, cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ);
    endtask : t_power

    task automatic t_reserved;
        logic [4:0] a [4] = '{5'h03, 5'h05, 5'h10, 5'h07};
        logic [7:0] e [4] = '{8'hdf, 8'he7, 8'h1f, 8'h00};
        cpm_pkg::cpm_route_t er = '{stereo_beep_to_headphone: 1'b1, mono_beep_to_headphone: 1'b1,
            mic_to_stereo_outputs: 1'b1, dac_to_stereo_outputs: 1'b1, headphone_mono: 1'b1,
            second_mono_output_enable_mode: cpm_pkg::SECOND_MONO_OUTPUT_ENABLE_HIZ, default: 1'b0};
        cpm_pkg::cpm_mode_t em = '{audio_format: 2'b10, sample_rate_mode: 3'b111, loopback: 1'b1,
            default: '0};
        for (int i = 0; i < 4; i++)
        begin
            wrs(a[i], 8'hff);
            rchk(a[i], e[i]);
        end
        chk("hp_mono", rt.headphone_mono, 1'b1);
        chk("loop", dac_word, 16'h1234);
        chk("route_hp", rt, er);
        chk("mode_rate", md, em);
        wrs(5'h00, 8'h90);
        chk("line_act", rt.line_output_active, 1'b1);
        wrs(5'h05, 8'h00);
        chk("noloop", dac_word, 16'habcd);
        wrs(5'h04, 8'h04);
        chk("bf_slave", md.bit_clock_32fs, 1'b0);
        @(posedge clk) master <= 1'b1;
        repeat (4) @(posedge clk);
        chk("bf_master", md.bit_clock_32fs, 1'b1);
    endtask : t_reserved

    task automatic t_dac;
        for (int c = 0; c < 4; c++)
        begin
            wrs(5'h06, {2'(c), 6'h11});
            chk("ramp", dc.mute_ramp_len, 11'h400 >> c);
        end
        wrs(5'h0d, 8'h33);
        wrs(5'h0c, 8'h5a);
        chk("linked", dc.right_att, 8'h5a);
        rchk(5'h0d, 8'h33);
        wrs(5'h06, 8'h20);
        chk("unlinked", dc.right_att, 8'h33);
        chk("mute", dc.soft_mute, 1'b1);
        chk("att_kept", dc.left_att, 8'h5a);
    endtask : t_dac

    task automatic stop_test;
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_defaults();
        t_power();
        t_reserved();
        t_dac();
        stop_test();
    end

    // Watchdog
    initial
    begin
        #20000;
        error_cnt++;
        stop_test();
    end
endmodule : test_cpm_regs
